//--- design/crsp_pkg.sv
// Package for the rising-event select and polarity block.
package crsp_pkg;

    // ------------------------------------------------------------
    // Register map (word addresses on the Avalon word bus)
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_DB_POL_CTRL   = 4'h0;
    localparam logic [3:0] ADDR_RISE_EN_LOW   = 4'h4;
    localparam logic [3:0] ADDR_RISE_EN_HIGH  = 4'h8;
    localparam logic [3:0] ADDR_RISE_MODE_LOW = 4'hC;
    localparam logic [3:0] ADDR_RISE_MODE_HI  = 4'h1;
    localparam logic [3:0] ADDR_STATUS        = 4'h2;
    localparam logic [3:0] ADDR_SHUTDOWN_CTRL = 4'h3;

    // ------------------------------------------------------------
    // Field layout and reset values
    // ------------------------------------------------------------
    localparam int          BIT_RISE_DB_SRC  = 7;
    localparam int          BIT_FALL_DB_SRC  = 6;
    localparam logic [7:0]  DB_POL_WMASK     = 8'hCF;
    localparam logic [7:0]  DB_POL_RESET     = 8'h00;
    localparam logic [7:0]  BYTE_RESET       = 8'h00;
    localparam int          BIT_SD_STATUS    = 0;
    localparam int          BIT_SD_RESTART   = 1;
    localparam logic [31:0] UNMAPPED_READ    = 32'h0000_0000;

    // Source index map.
    localparam int SRC_PIN       = 0;
    localparam int SRC_CMP_FIRST = 1;
    localparam int SRC_CCP_FIRST = 5;
    localparam int SRC_PWM_FIRST = 7;
    localparam int SRC_MOD       = 11;
    localparam int SRC_CLC_FIRST = 12;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [3:0] comparator;
        logic [1:0] capture;
        logic [3:0] pwm;
        logic       modulator;
        logic [3:0] logic_cell;
    } crsp_src_t;

    typedef struct packed {
        logic       rise_db_clock_sel;
        logic       fall_db_clock_sel;
        logic       rise_db_chain_sel;
        logic       fall_db_chain_sel;
        logic [3:0] out_polarity;
    } crsp_cfg_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT
    } crsp_bus_state_t;

endpackage

//--- design/crsp_rise_select.sv
// Rising-event source select, mode, dead-band source and polarity control.
//
// Function
// - The rise dead-band source bit picks the delay chain when set and the generator clock when clear.
// - The fall dead-band source bit picks the delay chain when set and the generator clock when clear.
// - Control bits 5 and 4 read as zero and ignore writes.
// - Polarity bits 0 to 3 make outputs A to D active low when set and active high when clear.
// - Sixteen rise source enable bits sit in a low and a high byte register.
// - Any mix of enables and modes works, all sources at once.
// - An enabled edge-mode source gives a rising event on a low-to-high change after the phase delay.
// - An enabled level-mode source gives an immediate rising event while high.
// - A disabled source never causes a rising event whatever its mode.
// - Source 0 is the pin, 1-4 comparators, 5-6 captures, 7-10 PWMs, 11 the modulator, 12-15 logic cells.
// - In shutdown with auto-restart, status clears on the first rising event after all shutdown inputs are false.
//
// Added by the designer: the register addresses and the Avalon-MM register port.
module crsp_rise_select
    import crsp_pkg::*;
#(
    parameter int PHASE_WIDTH = 8
) (
    input  wire logic                   clock,
    input  wire logic                   rst_b,
    // Avalon-MM slave.
    input  wire logic [3:0]             avs_address,
    input  wire logic                   avs_read,
    input  wire logic                   avs_write,
    input  wire logic [31:0]            avs_writedata,
    input  wire logic [3:0]             avs_byteenable,
    output logic      [31:0]            avs_readdata,
    output logic                        avs_waitrequest,
    // Event sources.
    input  wire logic                   event_pin_route,
    input  wire crsp_src_t              event_src,
    input  wire logic [PHASE_WIDTH-1:0] rise_phase_count,
    input  wire logic                   shutdown_inputs_true,
    // Results.
    output logic                        rise_event,
    output crsp_cfg_t                   cfg,
    output logic                        shutdown_status
);

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [7:0]  db_pol_reg;
    logic [7:0]  rise_en_low_reg;
    logic [7:0]  rise_en_high_reg;
    logic [7:0]  rise_mode_low_reg;
    logic [7:0]  rise_mode_high_reg;
    logic [1:0]  sd_ctrl_reg;
    crsp_bus_state_t bus_state_reg;
    logic [31:0] readdata_reg;

    logic [15:0] src_raw;
    logic [15:0] src_sync1_reg;
    logic [15:0] src_sync2_reg;
    logic [15:0] src_sync3_reg;
    logic [15:0] src_level_reg;
    logic [15:0] src_level_prev_reg;
    logic [15:0] enable_vec;
    logic [15:0] mode_vec;
    logic [15:0] edge_hit;
    logic [15:0] level_hit;
    logic        edge_any;
    logic        delayed_pending_reg;
    logic [PHASE_WIDTH-1:0] phase_cnt_reg;
    logic        delayed_fire;
    logic        wr_go;

    // Byte-lane merge used by every writable register except the shutdown control.
    function automatic logic [7:0] merge_byte(
        input logic [7:0] old_val,
        input logic [7:0] new_val,
        input logic [7:0] wmask,
        input logic       lane_en
    );
        merge_byte = lane_en ? ((old_val & ~wmask) | (new_val & wmask))
                             : old_val;
    endfunction

    // ------------------------------------------------------------
    // Source bundle
    // ------------------------------------------------------------
    // Index order follows the source index map in the package.
    assign src_raw = {event_src.logic_cell, event_src.modulator,
                      event_src.pwm, event_src.capture,
                      event_src.comparator, event_pin_route};

    // Three-stage synchronisers; a change is taken once stages agree.
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            src_sync1_reg <= 16'h0000;
            src_sync2_reg <= 16'h0000;
            src_sync3_reg <= 16'h0000;
        end else begin
            src_sync1_reg <= src_raw;
            src_sync2_reg <= src_sync1_reg;
            src_sync3_reg <= src_sync2_reg;
        end
    end

    // Filtered level moves only where the two later stages agree.
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            src_level_reg      <= 16'h0000;
            src_level_prev_reg <= 16'h0000;
        end else begin
            src_level_reg <= (src_sync2_reg & src_sync3_reg)
                           | (src_level_reg & (src_sync2_reg | src_sync3_reg));
            src_level_prev_reg <= src_level_reg;
        end
    end

    // ------------------------------------------------------------
    // Trigger logic
    // ------------------------------------------------------------
    // All sixteen lanes are evaluated in parallel, so any mix works.
    assign enable_vec = {rise_en_high_reg, rise_en_low_reg};
    assign mode_vec   = {rise_mode_high_reg, rise_mode_low_reg};
    assign edge_hit   = enable_vec & mode_vec
                      & src_level_reg & ~src_level_prev_reg;
    assign level_hit  = enable_vec & ~mode_vec & src_level_reg;
    assign edge_any   = |edge_hit;

    // Edge-mode triggers wait out the phase delay; a new edge while one
    // is pending restarts the count, so the later edge governs.
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            delayed_pending_reg <= 1'b0;
            phase_cnt_reg       <= '0;
        end else if (edge_any) begin
            delayed_pending_reg <= 1'b1;
            phase_cnt_reg       <= rise_phase_count;
        end else if (delayed_pending_reg) begin
            if (phase_cnt_reg == '0) begin
                delayed_pending_reg <= 1'b0;
            end else begin
                phase_cnt_reg <= phase_cnt_reg - 1'b1;
            end
        end
    end

    assign delayed_fire = delayed_pending_reg && (phase_cnt_reg == '0);

    // Single registered request combining every enabled source.
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            rise_event <= 1'b0;
        end else begin
            rise_event <= delayed_fire | (|level_hit);
        end
    end

    // ------------------------------------------------------------
    // Shutdown status with auto-restart
    // ------------------------------------------------------------
    // Software sets or clears the status; hardware clears it on restart.
    // The hardware clear wins because a restart is the later fact.
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            shutdown_status <= 1'b0;
        end else begin
            if (sd_ctrl_reg[BIT_SD_RESTART] && shutdown_status
                && !shutdown_inputs_true && rise_event) begin
                shutdown_status <= 1'b0;
            end else if (shutdown_inputs_true) begin
                shutdown_status <= 1'b1;
            end else if (wr_go && avs_address == ADDR_SHUTDOWN_CTRL
                         && avs_byteenable[0]) begin
                shutdown_status <= avs_writedata[BIT_SD_STATUS];
            end
        end
    end

    // ------------------------------------------------------------
    // Configuration outputs
    // ------------------------------------------------------------
    always_comb begin
        cfg.rise_db_chain_sel = db_pol_reg[BIT_RISE_DB_SRC];
        cfg.rise_db_clock_sel = ~db_pol_reg[BIT_RISE_DB_SRC];
        cfg.fall_db_chain_sel = db_pol_reg[BIT_FALL_DB_SRC];
        cfg.fall_db_clock_sel = ~db_pol_reg[BIT_FALL_DB_SRC];
        cfg.out_polarity      = db_pol_reg[3:0];
    end

    // ------------------------------------------------------------
    // Avalon-MM slave
    // ------------------------------------------------------------
    // One wait cycle per access: the request is taken in ST_IDLE, then
    // waitrequest drops in ST_WAIT, where write and read complete.
    assign wr_go = avs_write && (bus_state_reg == ST_WAIT);
    assign avs_waitrequest = (avs_read || avs_write)
                           && (bus_state_reg != ST_WAIT);
    assign avs_readdata = readdata_reg;

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            bus_state_reg <= ST_IDLE;
        end else begin
            case (bus_state_reg)
                ST_IDLE: begin
                    if (avs_read || avs_write) begin
                        bus_state_reg <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    bus_state_reg <= ST_IDLE;
                end
                default: begin
                    bus_state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // Register writes; only byte lane 0 carries data.
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            db_pol_reg         <= DB_POL_RESET;
            rise_en_low_reg    <= BYTE_RESET;
            rise_en_high_reg   <= BYTE_RESET;
            rise_mode_low_reg  <= BYTE_RESET;
            rise_mode_high_reg <= BYTE_RESET;
            sd_ctrl_reg        <= 2'b00;
        end else if (wr_go) begin
            case (avs_address)
                ADDR_DB_POL_CTRL: begin
                    db_pol_reg <= merge_byte(db_pol_reg, avs_writedata[7:0],
                        DB_POL_WMASK, avs_byteenable[0]);
                end
                ADDR_RISE_EN_LOW: begin
                    rise_en_low_reg <= merge_byte(rise_en_low_reg,
                        avs_writedata[7:0], 8'hFF, avs_byteenable[0]);
                end
                ADDR_RISE_EN_HIGH: begin
                    rise_en_high_reg <= merge_byte(rise_en_high_reg,
                        avs_writedata[7:0], 8'hFF, avs_byteenable[0]);
                end
                ADDR_RISE_MODE_LOW: begin
                    rise_mode_low_reg <= merge_byte(rise_mode_low_reg,
                        avs_writedata[7:0], 8'hFF, avs_byteenable[0]);
                end
                ADDR_RISE_MODE_HI: begin
                    rise_mode_high_reg <= merge_byte(rise_mode_high_reg,
                        avs_writedata[7:0], 8'hFF, avs_byteenable[0]);
                end
                ADDR_SHUTDOWN_CTRL: begin
                    if (avs_byteenable[0]) begin
                        sd_ctrl_reg <= avs_writedata[1:0];
                    end
                end
                default: begin
                    sd_ctrl_reg <= sd_ctrl_reg;
                end
            endcase
        end
    end

    // Read data is registered on the edge that takes the request in ST_IDLE and holds after.
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            readdata_reg <= UNMAPPED_READ;
        end else if (avs_read && bus_state_reg == ST_IDLE) begin
            case (avs_address)
                ADDR_DB_POL_CTRL:   readdata_reg <= {24'h000000,
                                        db_pol_reg & DB_POL_WMASK};
                ADDR_RISE_EN_LOW:   readdata_reg <= {24'h000000,
                                        rise_en_low_reg};
                ADDR_RISE_EN_HIGH:  readdata_reg <= {24'h000000,
                                        rise_en_high_reg};
                ADDR_RISE_MODE_LOW: readdata_reg <= {24'h000000,
                                        rise_mode_low_reg};
                ADDR_RISE_MODE_HI:  readdata_reg <= {24'h000000,
                                        rise_mode_high_reg};
                ADDR_STATUS:        readdata_reg <= {16'h0000,
                                        src_level_reg};
                ADDR_SHUTDOWN_CTRL: readdata_reg <= {30'h00000000,
                                        sd_ctrl_reg[BIT_SD_RESTART],
                                        shutdown_status};
                default:            readdata_reg <= UNMAPPED_READ;
            endcase
        end
    end

endmodule

//--- bench/crsp_src_model.sv
// Model of the peripherals that feed the sixteen rising-event sources.
module crsp_src_model
    import crsp_pkg::*;
(
    input  wire logic [15:0] lvl,
    output logic             event_pin_route,
    output crsp_src_t        event_src
);
    // Fields are filled by name, so the packed order of the struct
    // cannot shift a source onto the wrong lane.
    assign event_pin_route      = lvl[0];
    assign event_src.comparator = lvl[4:1];
    assign event_src.capture    = lvl[6:5];
    assign event_src.pwm        = lvl[10:7];
    assign event_src.modulator  = lvl[11];
    assign event_src.logic_cell = lvl[15:12];
endmodule

//--- bench/crsp_rise_select_chk.sv
// Concurrent checks on the ports of the rising-event select block.
module crsp_rise_select_chk
    import crsp_pkg::*;
#(
    parameter int PHASE_WIDTH = 8
) (
    input wire logic        clock,
    input wire logic        rst_b,
    input wire logic [3:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        event_pin_route,
    input wire logic        shutdown_inputs_true,
    input wire logic        rise_event,
    input wire crsp_cfg_t   cfg,
    input wire logic        shutdown_status
);
    // ------------------------------------------------------------
    // Helper logic
    // ------------------------------------------------------------
    logic [15:0] en_sh;
    logic [15:0] md_sh;
    logic [3:0]  zc;
    logic [3:0]  lc;
    logic        wdone;
    logic        wpol;

    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);

    // A write counts only at the edge where waitrequest is low.
    assign wdone = avs_write && !avs_waitrequest && avs_byteenable[0];
    assign wpol  = wdone && avs_address == ADDR_DB_POL_CTRL;

    // Shadow copies of the enable and mode bytes.
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            en_sh <= 16'h0000;
            md_sh <= 16'h0000;
        end else if (wdone) begin
            if (avs_address == ADDR_RISE_EN_LOW) en_sh[7:0] <= avs_writedata[7:0];
            if (avs_address == ADDR_RISE_EN_HIGH) en_sh[15:8] <= avs_writedata[7:0];
            if (avs_address == ADDR_RISE_MODE_LOW) md_sh[7:0] <= avs_writedata[7:0];
            if (avs_address == ADDR_RISE_MODE_HI) md_sh[15:8] <= avs_writedata[7:0];
        end
    end

    // Saturating counts of cycles with no enables and of a held pin level.
    always_ff @(posedge clock) begin
        if (!rst_b || en_sh != 16'h0000) zc <= 4'h0;
        else if (zc != 4'hF) zc <= zc + 4'h1;
        if (!rst_b || wdone || !(event_pin_route && en_sh[0] && !md_sh[0]))
            lc <= 4'h0;
        else if (lc != 4'hF) lc <= lc + 4'h1;
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    AST_RISE_SRC_WR: assert property (wpol |=> cfg.rise_db_chain_sel == $past(avs_writedata[BIT_RISE_DB_SRC]))
        else $error("rise dead-band source not taken");
    AST_RISE_SEL_EXCL: assert property (cfg.rise_db_clock_sel != cfg.rise_db_chain_sel)
        else $error("rise dead-band selects not exclusive");
    AST_FALL_SRC_WR: assert property (wpol |=> cfg.fall_db_clock_sel == !$past(avs_writedata[BIT_FALL_DB_SRC]))
        else $error("fall dead-band source not taken");
    AST_RSV_ZERO: assert property (avs_read && !avs_waitrequest && avs_address == ADDR_DB_POL_CTRL |-> avs_readdata[5:4] == 2'h0)
        else $error("unused control bits read nonzero");
    AST_POL_WR: assert property (wpol |=> cfg.out_polarity == $past(avs_writedata[3:0]))
        else $error("polarity bits not taken");
    AST_ONE_WAIT: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("more than one wait cycle");
    AST_LEVEL: assert property (lc >= 4'h7 |-> rise_event)
        else $error("level source gave no event");
    AST_NO_EN: assert property (zc >= 4'h8 |-> !rise_event)
        else $error("event with no source enabled");
    AST_SD_SET: assert property (shutdown_inputs_true |=> shutdown_status)
        else $error("shutdown status not set");

    cover property (lc == 4'h7);
    cover property (wpol);
    cover property ($fell(shutdown_status));
endmodule

//--- bench/crsp_rise_select_tb.sv
// Testbench for the rising-event select and polarity block.
module crsp_rise_select_tb
    import crsp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------
    // Signals, design and source model
    // ------------------------------------------------------------
    logic        clock = 1'b0;
    logic        rst_b = 1'b0;
    logic [3:0]  avs_address = 4'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0]  avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        event_pin_route;
    crsp_src_t   event_src;
    logic [7:0]  rise_phase_count = 8'h28;
    logic        shutdown_inputs_true = 1'b0;
    logic        rise_event;
    crsp_cfg_t   cfg;
    logic        shutdown_status;
    logic [15:0] lvl = 16'h0;
    logic [31:0] rd;
    int          err_count = 0;
    int          n_tests = 0;
    int          n1;
    int          n2;

    crsp_rise_select #(.PHASE_WIDTH(8)) u_crsp_rise_select (
        .clock(clock), .rst_b(rst_b), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .event_pin_route(event_pin_route), .event_src(event_src),
        .rise_phase_count(rise_phase_count),
        .shutdown_inputs_true(shutdown_inputs_true),
        .rise_event(rise_event), .cfg(cfg),
        .shutdown_status(shutdown_status));

    crsp_src_model u_crsp_src_model (
        .lvl(lvl), .event_pin_route(event_pin_route), .event_src(event_src));

    // A 100 ns clock.
    initial begin
        forever #50 clock = ~clock;
    end

    // Counts, verdict and end of run.
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            err_count++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, s, e);
        end
    endtask

    // One Avalon transfer; the request stands until waitrequest is low.
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [7:0] d, input logic [3:0] be);
        int k;
        k = 0;
        @(posedge clock);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_byteenable <= be;
        avs_write <= w;
        avs_read <= !w;
        do begin
            @(posedge clock);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 20);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (k >= 20) begin
            err_count++;
            finish_test;
        end
    endtask

    task automatic rchk(input logic [3:0] a, input logic [31:0] e);
        bus(1'b0, a, 8'h00, 4'hF);
        chk(rd, e);
    endtask

    // Modes go first so that no source is briefly enabled in edge mode.
    task automatic set_en(input logic [15:0] en, input logic [15:0] md);
        bus(1'b1, ADDR_RISE_MODE_LOW, md[7:0], 4'hF);
        bus(1'b1, ADDR_RISE_MODE_HI, md[15:8], 4'hF);
        bus(1'b1, ADDR_RISE_EN_LOW, en[7:0], 4'hF);
        bus(1'b1, ADDR_RISE_EN_HIGH, en[15:8], 4'hF);
    endtask

    task automatic wait_ev(input logic v, input int lim, output int n);
        n = 0;
        while (rise_event !== v && n < lim) begin
            @(posedge clock);
            n++;
        end
        if (n >= lim) begin
            err_count++;
            finish_test;
        end
    endtask

    // Main sequence; the phase count starts at 40 clocks.
    initial begin
        repeat (12) @(posedge clock);
        rst_b <= 1'b1;
        rchk(ADDR_DB_POL_CTRL, 32'h0);
        chk(32'(cfg), 32'hC0);
        bus(1'b1, ADDR_DB_POL_CTRL, 8'hFF, 4'hF);
        rchk(ADDR_DB_POL_CTRL, 32'hCF);
        chk(32'(cfg), 32'h3F);
        bus(1'b1, ADDR_DB_POL_CTRL, 8'h45, 4'h0);
        rchk(ADDR_DB_POL_CTRL, 32'hCF);
        bus(1'b1, ADDR_DB_POL_CTRL, 8'h45, 4'hF);
        rchk(ADDR_DB_POL_CTRL, 32'h45);
        chk(32'(cfg), 32'h95);
        rchk(ADDR_RISE_EN_LOW, 32'h0);
        rchk(ADDR_RISE_EN_HIGH, 32'h0);
        rchk(ADDR_RISE_MODE_LOW, 32'h0);
        rchk(ADDR_RISE_MODE_HI, 32'h0);
        bus(1'b1, 4'h5, 8'hFF, 4'hF);
        rchk(4'h5, 32'h0);
        set_en(16'h5AA5, 16'hC33C);
        rchk(ADDR_RISE_EN_LOW, 32'hA5);
        rchk(ADDR_RISE_EN_HIGH, 32'h5A);
        rchk(ADDR_RISE_MODE_LOW, 32'h3C);
        rchk(ADDR_RISE_MODE_HI, 32'hC3);
        $display("test registers done");
        for (int n = 0; n < 16; n++) begin
            set_en(~(16'h1 << n), 16'h1 << n);
            lvl <= 16'h1 << n;
            repeat (12) @(posedge clock);
            chk(32'(rise_event), 32'h0);
            set_en(16'h1 << n, 16'h0);
            wait_ev(1'b1, 10, n1);
            chk(32'(rise_event), 32'h1);
            lvl <= 16'h0;
            wait_ev(1'b0, 10, n1);
        end
        $display("test sources done");
        set_en(16'h0008, 16'h0008);
        rise_phase_count <= 8'h0A;
        lvl <= 16'h0008;
        wait_ev(1'b1, 60, n1);
        chk(32'(n1 > 10), 32'h1);
        @(posedge clock);
        chk(32'(rise_event), 32'h0);
        lvl <= 16'h0;
        repeat (8) @(posedge clock);
        rise_phase_count <= 8'h14;
        lvl <= 16'h0008;
        wait_ev(1'b1, 60, n2);
        chk(32'(n2 - n1), 32'hA);
        // Drop the source before its mode turns to level, else the next
        // test starts with a stale event already standing.
        lvl <= 16'h0;
        repeat (8) @(posedge clock);
        $display("test edge done");
        set_en(16'h1002, 16'h0000);
        lvl <= 16'h1000;
        wait_ev(1'b1, 10, n1);
        lvl <= 16'h1002;
        repeat (3) @(posedge clock);
        lvl <= 16'h0002;
        repeat (6) @(posedge clock);
        chk(32'(rise_event), 32'h1);
        lvl <= 16'h0;
        wait_ev(1'b0, 10, n1);
        $display("test combine done");
        bus(1'b1, ADDR_SHUTDOWN_CTRL, 8'h02, 4'hF);
        set_en(16'h0001, 16'h0000);
        shutdown_inputs_true <= 1'b1;
        repeat (3) @(posedge clock);
        chk(32'(shutdown_status), 32'h1);
        shutdown_inputs_true <= 1'b0;
        repeat (3) @(posedge clock);
        chk(32'(shutdown_status), 32'h1);
        lvl <= 16'h0001;
        wait_ev(1'b1, 10, n1);
        repeat (2) @(posedge clock);
        chk(32'(shutdown_status), 32'h0);
        rchk(ADDR_SHUTDOWN_CTRL, 32'h2);
        rchk(ADDR_STATUS, 32'h1);
        $display("test restart done");
        finish_test;
    end
endmodule

bind crsp_rise_select crsp_rise_select_chk #(.PHASE_WIDTH(PHASE_WIDTH))
    u_crsp_rise_select_chk (
    .clock(clock), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .event_pin_route(event_pin_route),
    .shutdown_inputs_true(shutdown_inputs_true),
    .rise_event(rise_event), .cfg(cfg), .shutdown_status(shutdown_status));
